// ===== hdl/dac_rb_pkg.sv
// Purpose: Shared constants for the two-wire DAC readback link.
// Assumes: Both ends sample the bus with a 125 MHz system clock.
// Notes: Contract list below; tags mark where each item is carried out.
// Contract
// [RULE_01] Write address then control byte, both acknowledged.
// [RULE_02] Repeated start, read address acknowledged, device transmits.
// [RULE_03] Device acknowledges by pulling data low.
// [RULE_04] Flag clear: high byte then low byte.
// [RULE_05] Flag set: power-down, high, low bytes.
// [RULE_06] Channel select chooses returned channel value.
// [RULE_07] Control byte field layout is fixed.
// [RULE_08] High byte holds code bits eleven to four.
// [RULE_09] Low byte upper nibble holds code bits three-zero.
// [RULE_10] Power-down byte: mode bits, then six ones.
// [RULE_11] Master acknowledges all bytes except last.
// [RULE_12] Master ends with stop or repeated start.
// [RULE_13] Master prefers repeated start, then write address.
// [RULE_14] High-speed master code is never acknowledged.
// [RULE_15] After master code, readback proceeds unchanged.
// [RULE_16] Power-up clears every DAC register to zero.
// [RULE_17] Device never holds the clock line low.
// [RULE_18] Address is 10011 plus two pin bits.
// [RULE_19] Device keeps last channel select and flag.
package dac_rb_pkg;
    // ==========================================================
    // Address and control byte layout.
    localparam logic [4:0] ADDR_FIXED = 5'h13;
    localparam int CTRL_PD_POS = 0;
    localparam int CTRL_SEL_LO = 1;
    localparam int CTRL_SEL_HI = 2;
    localparam int CTRL_LOAD_LO = 4;
    localparam int CTRL_LOAD_HI = 5;
    localparam logic [4:0] HS_CODE = 5'h01;
    localparam logic [5:0] PD_BYTE_ONES = 6'h3f;
    localparam logic [3:0] LOW_PAD = 4'h0;
    localparam int NUM_CHAN = 4;
    localparam int CODE_W = 12;
    // ==========================================================
    // Master timing: link clock half period in system clocks.
    localparam int SCL_HALF_NS = 80;
    localparam int CLK_NS = 8;
    localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
endpackage : dac_rb_pkg

// ===== hdl/dac_rb_if.sv
// Purpose: Open-drain two-wire bus joining master and device.
// Assumes: Pull-ups make an undriven line read high.
// Notes: Output enables are active low.
`timescale 1ns/100ps
`default_nettype none
interface dac_rb_if;
    logic scl_o_m;
    logic scl_oe_n_m;
    logic sda_o_m;
    logic sda_oe_n_m;
    logic scl_o_s;
    logic scl_oe_n_s;
    logic sda_o_s;
    logic sda_oe_n_s;
    logic scl;
    logic sda;
    assign scl = !((!scl_oe_n_m && !scl_o_m) || (!scl_oe_n_s && !scl_o_s));
    assign sda = !((!sda_oe_n_m && !sda_o_m) || (!sda_oe_n_s && !sda_o_s));
    modport master (
        output scl_o_m, scl_oe_n_m, sda_o_m, sda_oe_n_m,
        input scl, sda
    );
    modport device (
        output scl_o_s, scl_oe_n_s, sda_o_s, sda_oe_n_s,
        input scl, sda
    );
endinterface : dac_rb_if
`default_nettype wire

// ===== hdl/dac_rb_device.sv
// Purpose: Two-wire slave that returns stored DAC channel codes.
// Assumes: Bus is sampled by clk through two flip-flops.
// Notes: Write data phase is outside this block; codes load on a port.
`timescale 1ns/100ps
`default_nettype none
module dac_rb_device (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Bus.
    dac_rb_if.device bus,
    // Address pins.
    input wire logic addr_pin_hi,
    input wire logic addr_pin_lo,
    // Code load from the write path.
    input wire logic code_we,
    input wire logic [1:0] code_chan,
    input wire logic [11:0] code_val,
    input wire logic [1:0] code_pd,
    // Status.
    output logic [1:0] chan_sel_q,
    output logic pd_select_flag_q
);
    typedef enum {S_IDLE, S_RX, S_ACK, S_TX, S_MACK} state_e;
    state_e st_q;
    logic [2:0] scl_s_q, sda_s_q;
    logic [7:0] sh_q;
    logic [3:0] cnt_q;
    logic rd_q, ctl_q, hit_q, ack_q;
    logic [1:0] byte_q;
    logic sda_o_q;
    logic [11:0] code_q [dac_rb_pkg::NUM_CHAN];
    logic [1:0] pdm_q [dac_rb_pkg::NUM_CHAN];
    logic [1:0] pins_q;
    logic [1:0] pins_s_q;
    logic [7:0] tx_cur;
    logic [7:0] tx_nxt;
    wire scl_r = scl_s_q[1] && !scl_s_q[2];
    wire scl_f = !scl_s_q[1] && scl_s_q[2];
    wire start = scl_s_q[1] && scl_s_q[2] && sda_s_q[2] && !sda_s_q[1];
    wire stop = scl_s_q[1] && scl_s_q[2] && !sda_s_q[2] && sda_s_q[1];

    function automatic logic [7:0] tx_byte(input logic [1:0] n,
        input logic pd, input logic [11:0] c, input logic [1:0] m);
        logic [1:0] k;
        k = pd ? n : n + 2'h1;
        case (k)
            2'h0: tx_byte = {m, dac_rb_pkg::PD_BYTE_ONES}; // [RULE_10]
            2'h1: tx_byte = c[11:4]; // [RULE_08]
            default: tx_byte = {c[3:0], dac_rb_pkg::LOW_PAD}; // [RULE_09]
        endcase
    endfunction : tx_byte

    // Byte for the current index and for the one after it.
    assign tx_cur = tx_byte(byte_q, pd_select_flag_q, code_q[chan_sel_q],
        pdm_q[chan_sel_q]);
    assign tx_nxt = tx_byte(byte_q + 2'h1, pd_select_flag_q,
        code_q[chan_sel_q], pdm_q[chan_sel_q]);

    // ==========================================================
    // Synchronisers; the clock line is never driven.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            pins_s_q <= 2'h0;
            pins_q <= 2'h0;
        end
        else
        begin
            scl_s_q <= {scl_s_q[1:0], bus.scl};
            sda_s_q <= {sda_s_q[1:0], bus.sda};
            pins_s_q <= {addr_pin_hi, addr_pin_lo};
            pins_q <= pins_s_q;
        end
    end
    assign bus.scl_o_s = 1'b1;
    assign bus.scl_oe_n_s = 1'b1; // [RULE_17]
    assign bus.sda_o_s = 1'b0;
    assign bus.sda_oe_n_s = sda_o_q;

    // ==========================================================
    // Channel code storage, cleared at power-up.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < dac_rb_pkg::NUM_CHAN; i++)
            begin
                code_q[i] <= 12'h000; // [RULE_16]
                pdm_q[i] <= 2'h0;
            end
        end
        else if (code_we)
        begin
            code_q[code_chan] <= code_val;
            pdm_q[code_chan] <= code_pd;
        end
    end

    // ==========================================================
    // Protocol engine.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q <= S_IDLE;
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            rd_q <= 1'b0;
            ctl_q <= 1'b0;
            hit_q <= 1'b0;
            ack_q <= 1'b0;
            byte_q <= 2'h0;
            sda_o_q <= 1'b1;
            chan_sel_q <= 2'h0;
            pd_select_flag_q <= 1'b0;
        end
        else if (start)
        begin
            // [RULE_02] [RULE_12] [RULE_15]
            st_q <= S_RX;
            cnt_q <= 4'h0;
            hit_q <= 1'b0;
            sda_o_q <= 1'b1;
        end
        else if (stop)
        begin
            st_q <= S_IDLE;
            sda_o_q <= 1'b1;
        end
        else
        begin
            unique case (st_q)
                S_IDLE:
                begin
                    sda_o_q <= 1'b1;
                end
                S_RX:
                begin
                    if (scl_r)
                    begin
                        sh_q <= {sh_q[6:0], sda_s_q[1]};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    else if (scl_f && cnt_q == 4'h8)
                    begin
                        cnt_q <= 4'h0;
                        st_q <= S_ACK;
                        if (!hit_q)
                        begin
                            // [RULE_18] [RULE_14]
                            if (sh_q[7:3] == dac_rb_pkg::ADDR_FIXED &&
                                sh_q[2:1] == pins_q)
                            begin
                                hit_q <= 1'b1;
                                rd_q <= sh_q[0];
                                ctl_q <= !sh_q[0];
                                byte_q <= 2'h0;
                                sda_o_q <= 1'b0; // [RULE_03]
                            end
                            else
                                st_q <= S_IDLE;
                        end
                        else if (ctl_q)
                        begin
                            // [RULE_01] [RULE_07] [RULE_19]
                            chan_sel_q <= sh_q[dac_rb_pkg::CTRL_SEL_HI:
                                dac_rb_pkg::CTRL_SEL_LO];
                            pd_select_flag_q <= sh_q[dac_rb_pkg::CTRL_PD_POS];
                            ctl_q <= 1'b0;
                            sda_o_q <= 1'b0; // [RULE_03]
                        end
                        else
                            st_q <= S_IDLE;
                    end
                end
                S_ACK:
                begin
                    if (scl_f)
                    begin
                        if (rd_q)
                        begin
                            // [RULE_06] [RULE_04] [RULE_05]
                            sh_q <= tx_cur;
                            sda_o_q <= tx_cur[7];
                            cnt_q <= 4'h1;
                            st_q <= S_TX;
                        end
                        else
                        begin
                            sda_o_q <= 1'b1;
                            st_q <= ctl_q ? S_RX : S_IDLE;
                        end
                    end
                end
                S_TX:
                begin
                    if (scl_f)
                    begin
                        if (cnt_q == 4'h8)
                        begin
                            sda_o_q <= 1'b1;
                            st_q <= S_MACK;
                        end
                        else
                        begin
                            sda_o_q <= sh_q[6];
                            sh_q <= {sh_q[6:0], 1'b0};
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                S_MACK:
                begin
                    if (scl_r)
                        ack_q <= !sda_s_q[1];
                    else if (scl_f)
                    begin
                        byte_q <= byte_q + 2'h1;
                        // [RULE_11]
                        if (ack_q &&
                            byte_q != (pd_select_flag_q ? 2'h2 : 2'h1))
                        begin
                            // Next byte leaves on this same falling edge.
                            sh_q <= tx_nxt;
                            sda_o_q <= tx_nxt[7];
                            cnt_q <= 4'h1;
                            st_q <= S_TX;
                        end
                        else
                            st_q <= S_IDLE;
                    end
                end
            endcase
        end
    end
endmodule : dac_rb_device
`default_nettype wire

// ===== hdl/dac_rb_master.sv
// Purpose: Two-wire master performing one readback per request.
// Assumes: Device never stretches the clock.
// Notes: Optional high-speed preamble with the master code.
`timescale 1ns/100ps
`default_nettype none
module dac_rb_master (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Bus.
    dac_rb_if.master bus,
    // Request.
    input wire logic req,
    input wire logic [1:0] req_addr,
    input wire logic [1:0] req_chan,
    input wire logic req_pd,
    input wire logic req_hs,
    // Answer.
    output logic busy_q,
    output logic done_q,
    output logic [23:0] rdata_q,
    output logic nack_q
);
    typedef enum {M_IDLE, M_START, M_BYTE, M_STOP} mst_e;
    mst_e st_q;
    logic [7:0] phase_cnt_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [2:0] idx_q, last_q;
    logic [8:0] sh_q;
    logic [1:0] sda_s_q;
    logic scl_q, sda_q;
    logic [6:0] addr_q;
    logic [7:0] ctrl_q;
    logic hs_q;
    logic [7:0] byte_cur;
    logic [7:0] byte_nxt;
    wire tick = phase_cnt_q == 8'(dac_rb_pkg::SCL_HALF_CYC - 1);

    // Byte sequence: optional code, write addr, ctrl, read addr, reads.
    function automatic logic [7:0] seq_byte(input logic [2:0] i,
        input logic [6:0] a, input logic [7:0] c);
        case (i)
            3'h0: seq_byte = {dac_rb_pkg::HS_CODE, 3'h0}; // [RULE_14]
            3'h1: seq_byte = {a, 1'b0}; // [RULE_01]
            3'h2: seq_byte = c;
            3'h3: seq_byte = {a, 1'b1}; // [RULE_02]
            default: seq_byte = 8'hff;
        endcase
    endfunction : seq_byte

    // Byte for the current index and for the one after it.
    assign byte_cur = seq_byte(idx_q, addr_q, ctrl_q);
    assign byte_nxt = seq_byte(idx_q + 3'h1, addr_q, ctrl_q);

    assign bus.scl_o_m = 1'b0;
    assign bus.scl_oe_n_m = scl_q;
    assign bus.sda_o_m = 1'b0;
    assign bus.sda_oe_n_m = sda_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            sda_s_q <= 2'h3;
        else
            sda_s_q <= {sda_s_q[0], bus.sda};
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q <= M_IDLE;
            phase_cnt_q <= 8'h00;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            idx_q <= 3'h0;
            last_q <= 3'h0;
            sh_q <= 9'h000;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            addr_q <= 7'h00;
            ctrl_q <= 8'h00;
            hs_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= 24'h000000;
            nack_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            phase_cnt_q <= tick ? 8'h00 : phase_cnt_q + 8'h01;
            unique case (st_q)
                M_IDLE:
                begin
                    phase_cnt_q <= 8'h00;
                    if (req)
                    begin
                        addr_q <= {dac_rb_pkg::ADDR_FIXED, req_addr};
                        // [RULE_07]
                        ctrl_q <= {5'h00, req_chan, req_pd};
                        hs_q <= req_hs;
                        idx_q <= req_hs ? 3'h0 : 3'h1;
                        last_q <= req_pd ? 3'h6 : 3'h5; // [RULE_04] [RULE_05]
                        nack_q <= 1'b0;
                        busy_q <= 1'b1;
                        ph_q <= 2'h0;
                        st_q <= M_START;
                    end
                end
                M_START:
                begin
                    if (tick)
                    begin
                        ph_q <= ph_q + 2'h1;
                        unique case (ph_q)
                            2'h0:
                            begin
                                scl_q <= 1'b1;
                                sda_q <= 1'b1;
                            end
                            2'h1: sda_q <= 1'b0;
                            2'h2: scl_q <= 1'b0;
                            default:
                            begin
                                sh_q <= {byte_cur, 1'b1};
                                sda_q <= byte_cur[7];
                                bit_q <= 4'h0;
                                ph_q <= 2'h0;
                                st_q <= M_BYTE;
                            end
                        endcase
                    end
                end
                M_BYTE:
                begin
                    if (tick)
                    begin
                        scl_q <= !scl_q;
                        if (!scl_q)
                        begin
                            sh_q <= {sh_q[7:0], sda_s_q[1]};
                        end
                        else if (bit_q != 4'h8)
                        begin
                            bit_q <= bit_q + 4'h1;
                            sda_q <= (bit_q == 4'h7) ?
                                (idx_q < 3'h4 || idx_q == last_q) : sh_q[8];
                        end
                        else
                        begin
                            // Ninth clock just ended; sh_q[0] is ack level.
                            if (idx_q >= 3'h4)
                                rdata_q <= {rdata_q[15:0], sh_q[8:1]};
                            else if (idx_q != 3'h0 && sh_q[0])
                                nack_q <= 1'b1;
                            idx_q <= idx_q + 3'h1;
                            if (idx_q == 3'h0 || idx_q == 3'h2)
                            begin
                                // [RULE_15] [RULE_13]
                                sda_q <= 1'b1;
                                ph_q <= 2'h0;
                                st_q <= M_START;
                            end
                            else if (idx_q == last_q ||
                                (idx_q < 3'h4 && sh_q[0]))
                            begin
                                sda_q <= 1'b0; // [RULE_12]
                                ph_q <= 2'h0;
                                st_q <= M_STOP;
                            end
                            else
                            begin
                                sh_q <= {byte_nxt, 1'b1};
                                sda_q <= byte_nxt[7];
                                bit_q <= 4'h0;
                            end
                        end
                    end
                end
                M_STOP:
                begin
                    if (tick)
                    begin
                        ph_q <= ph_q + 2'h1;
                        if (ph_q == 2'h0)
                            scl_q <= 1'b1;
                        else if (ph_q == 2'h1)
                            sda_q <= 1'b1;
                        else
                        begin
                            busy_q <= 1'b0;
                            done_q <= 1'b1;
                            st_q <= M_IDLE;
                        end
                    end
                end
            endcase
        end
    end
endmodule : dac_rb_master
`default_nettype wire

// ===== bench/dac_rb_sva.sv
// Purpose: Wire checker for the two-wire readback link.
// Assumes: Inputs are the signals of the interface joining both ends.
// Notes: Bytes are decoded from the wire with clk samples.
`timescale 1ns/100ps
`default_nettype none
module dac_rb_sva #(
    parameter logic [1:0] PINS = 2'h2
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Bus.
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_o_s,
    input wire logic scl_oe_n_s,
    input wire logic sda_o_s,
    input wire logic sda_oe_n_s
);
    // ==========
    // Byte decoder.
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_q;
    logic [2:0] byte_q;
    logic [7:0] sh_q;
    logic rd_q;
    logic ours_q;
    logic pd_q;
    logic rise;
    logic start;
    logic ack;
    logic dev_pull;
    logic [6:0] me;
    assign rise = scl && !scl_q;
    assign start = scl && scl_q && sda_q && !sda;
    assign ack = rise && bit_q == 4'h8;
    assign dev_pull = !sda_oe_n_s && !sda_o_s;
    assign me = {dac_rb_pkg::ADDR_FIXED, PINS};
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bit_q <= 4'h0;
            byte_q <= 3'h0;
            sh_q <= 8'h00;
            rd_q <= 1'b0;
            ours_q <= 1'b0;
            pd_q <= 1'b0;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda;
            if (start)
            begin
                bit_q <= 4'h0;
                byte_q <= 3'h0;
            end
            else if (ack)
            begin
                bit_q <= 4'h0;
                byte_q <= byte_q + 3'h1;
                if (byte_q == 3'h0)
                begin
                    rd_q <= sh_q[0];
                    ours_q <= sh_q[7:1] == me;
                end
                if (byte_q == 3'h1 && ours_q && !rd_q)
                    pd_q <= sh_q[dac_rb_pkg::CTRL_PD_POS];
            end
            else if (rise)
            begin
                bit_q <= bit_q + 4'h1;
                sh_q <= {sh_q[6:0], sda};
            end
        end
    end
    // ==========
    // Assertions.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    no_stretch_a: assert property (scl_oe_n_s || scl_o_s)
        else $error("device pulled the clock line low");
    sda_steady_a: assert property (scl && scl_q |-> $stable(dev_pull))
        else $error("device moved the data line while clock high");
    hs_nack_a: assert property (ack && byte_q == 3'h0
        && sh_q[7:3] == dac_rb_pkg::HS_CODE |-> sda)
        else $error("master code was acknowledged");
    foreign_nack_a: assert property (ack && byte_q == 3'h0
        && sh_q[7:1] != me |-> sda)
        else $error("foreign address was acknowledged");
    addr_ack_a: assert property (ack && byte_q == 3'h0
        && sh_q[7:1] == me |-> !sda)
        else $error("own address not acknowledged");
    ctrl_ack_a: assert property (ack && byte_q == 3'h1
        && ours_q && !rd_q |-> !sda)
        else $error("control byte not acknowledged");
    ctrl_layout_a: assert property (ack && byte_q == 3'h1
        && ours_q && !rd_q |-> sh_q[7:6] == 2'h0)
        else $error("control byte top bits not zero");
    pd_ones_a: assert property (ack && byte_q == 3'h1 && ours_q
        && rd_q && pd_q |-> sh_q[5:0] == dac_rb_pkg::PD_BYTE_ONES)
        else $error("power-down byte low bits not ones");
    read_ack_a: assert property (ack && byte_q != 3'h0
        && ours_q && rd_q |-> sda == (byte_q == (pd_q ? 3'h3 : 3'h2)))
        else $error("read byte count or acknowledge wrong");
    cover property (ack && byte_q == 3'h0 && sh_q[7:3] == 5'h01);
    cover property (ack && ours_q && rd_q && byte_q == 3'h3);
    cover property (ack && byte_q == 3'h0 && sh_q[7:1] != me);
endmodule : dac_rb_sva
`default_nettype wire

// ===== bench/dac_rb_tb.sv
// Purpose: Self-checking bench for the readback link.
// Assumes: Address pins are tied to 2'h2.
// Notes: Codes are loaded through the device's code port.
`timescale 1ns/100ps
`default_nettype none
module dac_rb_tb;
    // ==========
    // Signals.
    localparam logic [1:0] PINS = 2'h2;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic req = 1'b0;
    logic [1:0] req_addr = 2'h0;
    logic [1:0] req_chan = 2'h0;
    logic req_pd = 1'b0;
    logic req_hs = 1'b0;
    logic code_we = 1'b0;
    logic [1:0] code_chan = 2'h0;
    logic [11:0] code_val = 12'h000;
    logic [1:0] code_pd = 2'h0;
    logic busy_q;
    logic done_q;
    logic [23:0] rdata_q;
    logic nack_q;
    logic [1:0] chan_sel_q;
    logic pd_select_flag_q;
    logic loaded = 1'b0;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [11:0] codes [4] = '{12'ha5c, 12'h3f1, 12'hfff, 12'h801};
    logic [1:0] modes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    always #4 clk = ~clk;
    // ==========
    // Instances.
    dac_rb_if rb_bus ();
    dac_rb_master dac_rb_master_inst (.clk(clk), .arst_n(arst_n),
        .bus(rb_bus), .req(req), .req_addr(req_addr), .req_chan(req_chan),
        .req_pd(req_pd), .req_hs(req_hs), .busy_q(busy_q), .done_q(done_q),
        .rdata_q(rdata_q), .nack_q(nack_q));
    dac_rb_device dac_rb_device_inst (.clk(clk), .arst_n(arst_n),
        .bus(rb_bus), .addr_pin_hi(PINS[1]), .addr_pin_lo(PINS[0]),
        .code_we(code_we), .code_chan(code_chan), .code_val(code_val),
        .code_pd(code_pd), .chan_sel_q(chan_sel_q),
        .pd_select_flag_q(pd_select_flag_q));
    dac_rb_sva #(.PINS(PINS)) dac_rb_sva_inst (.clk(clk), .arst_n(arst_n),
        .scl(rb_bus.scl), .sda(rb_bus.sda), .scl_o_s(rb_bus.scl_o_s),
        .scl_oe_n_s(rb_bus.scl_oe_n_s), .sda_o_s(rb_bus.sda_o_s),
        .sda_oe_n_s(rb_bus.sda_oe_n_s));
    // ==========
    // Tasks.
    task automatic test_done();
        if (mismatches == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [23:0] seen,
            input logic [23:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic read_back(input logic [1:0] addr, input logic [1:0] ch,
            input logic pd, input logic hs);
        int n;
        n = 0;
        while (busy_q !== 1'b0)
            @(negedge clk);
        @(posedge clk);
        req <= 1'b1;
        req_addr <= addr;
        req_chan <= ch;
        req_pd <= pd;
        req_hs <= hs;
        @(posedge clk);
        req <= 1'b0;
        while (done_q !== 1'b1 && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
        check("done", {23'h0, done_q}, 24'h1);
        check("busy", {23'h0, busy_q}, 24'h0);
    endtask : read_back
    task automatic expect_read(input logic [1:0] ch, input logic pd,
            input logic hs);
        logic [11:0] c;
        logic [1:0] m;
        c = loaded ? codes[ch] : 12'h000;
        m = loaded ? modes[ch] : 2'h0;
        read_back(PINS, ch, pd, hs);
        check("nack", {23'h0, nack_q}, 24'h0);
        check("chan", {22'h0, chan_sel_q}, {22'h0, ch});
        check("flag", {23'h0, pd_select_flag_q}, {23'h0, pd});
        if (pd)
            check("rdata", rdata_q, {m, dac_rb_pkg::PD_BYTE_ONES, c,
                dac_rb_pkg::LOW_PAD});
        else
            check("rdata", {8'h0, rdata_q[15:0]}, {8'h0, c,
                dac_rb_pkg::LOW_PAD});
    endtask : expect_read
    // ==========
    // Sequence.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            mismatches++;
            test_done();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        expect_read(2'h3, 1'b1, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            code_we <= 1'b1;
            code_chan <= i[1:0];
            code_val <= codes[i];
            code_pd <= modes[i];
        end
        @(posedge clk);
        code_we <= 1'b0;
        loaded = 1'b1;
        for (int k = 0; k < 16; k++)
            expect_read(k[1:0], k[2], k[3]);
        read_back(2'h1, 2'h0, 1'b0, 1'b0);
        check("foreign nack", {23'h0, nack_q}, 24'h1);
        check("chan kept", {22'h0, chan_sel_q}, 24'h3);
        expect_read(2'h1, 1'b0, 1'b1);
        test_done();
    end
endmodule : dac_rb_tb
`default_nettype wire
